// ===== rtl/acc_ctrl.v
// Functional notes
// - Result is one when positive input exceeds negative, else zero.
// - Interrupt condition is a result toggle matching the edge mode; vector zero.
// - Interrupt condition sets the status interrupt flag.
// - Request is high while enable bit and flag are both set.
// - While enabled, result drives the event output continuously.
// - Enable bit turns comparator on; pad enable routes result to pin.
// - Hysteresis field selects off, 10, 25 or 50 mV for the core.
// - Low-power bit puts core into reduced-current, slower mode.
// - Negative mux offers pin, converter, reference; positive is one pin.
// - Idle sleep behaves exactly like active mode.
// - Standby: off unless run bit; clockless keeps events and pad only.
// - Power-down disables comparator and pad output.
// - Debug halt changes nothing.
// - Edge mode: 0 both, 2 falling, 3 rising, 1 reserved.
// - Negative select: 0 pin, 2 reference, 3 converter, 1 reserved.
// - Invert bit inverts result for all consumers and status.
// - State bit shows result after three-cycle sync; writing one clears flag.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "acc_map.vh"
module acc_ctrl #(
  parameter SYNC_STAGES = `ACC_SYNC_STAGES
) (
  input wire CLK,
  input wire ARST_N,
  input wire [2:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  input wire CORE_OUT,
  input wire SLEEP_IDLE,
  input wire SLEEP_STANDBY,
  input wire SLEEP_PDOWN,
  input wire CLK_REQ_OTHER,
  input wire DEBUG_HALT,
  output reg CORE_EN,
  output reg CORE_LP,
  output reg [1:0] CORE_HYS,
  output reg [1:0] CORE_NEG_SEL,
  output reg CORE_POS_SEL,
  output reg EVENT_OUT,
  output reg PAD_OUT,
  output reg PAD_OE,
  output reg IRQ,
  output reg [7:0] IRQ_VECTOR
);
  // ****************************************
  // Timing constants
  // ****************************************
  // Start-up waits are software's duty; kept for reference, no gating
  localparam START_CYC = (`ACC_START_NS * `ACC_CLK_MHZ + 999) / 1000;
  localparam VREF_START_CYC = (`ACC_VREF_START_NS * `ACC_CLK_MHZ + 999) / 1000;

  // ****************************************
  // Register bank
  // ****************************************
  reg [7:0] ctrl_reg;
  reg [7:0] mux_reg;
  reg ien_reg;
  reg flag_reg;
  reg flag_next;
  reg prev_reg;

  wire en_bit = ctrl_reg[`ACC_CTRL_EN];
  wire [1:0] hys = ctrl_reg[`ACC_CTRL_HYS_LO+1:`ACC_CTRL_HYS_LO];
  wire lp_bit = ctrl_reg[`ACC_CTRL_LP];
  wire [1:0] mode = ctrl_reg[`ACC_CTRL_MODE_LO+1:`ACC_CTRL_MODE_LO];
  wire pin_output_enable_bit = ctrl_reg[`ACC_CTRL_PIN_OUTPUT_ENABLE];
  wire rstby_bit = ctrl_reg[`ACC_CTRL_RSTBY];
  wire inv_bit = mux_reg[`ACC_MUX_INV];

  // Address decode used by the write paths; the read path decodes ADDR in its own case
  function sel;
    input [2:0] a;
    input [2:0] ofs;
    begin
      sel = (a == ofs);
    end
  endfunction

  // ****************************************
  // Power state
  // ****************************************
  // Idle and debug halt are deliberately not terms here
  wire active_run = en_bit & ~SLEEP_PDOWN & (~SLEEP_STANDBY | rstby_bit);
  // Clock is kept only when another module asks for it in standby
  wire status_live = ~SLEEP_STANDBY | CLK_REQ_OTHER;

  // ****************************************
  // Result path
  // ****************************************
  // Core compares positive against negative; result is asynchronous
  wire res_sync;
  acc_sync #(
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .clk(CLK),
    .arst_n(ARST_N),
    .d(CORE_OUT),
    .q(res_sync)
  );

  // Inverted result feeds every consumer
  wire res = (res_sync ^ inv_bit) & active_run;

  // ****************************************
  // Edge detection
  // ****************************************
  // Edge qualification by mode
  wire rise = res & ~prev_reg;
  wire fall = ~res & prev_reg;
  reg hit;
  always @* begin
    hit = 1'b0;
    case (mode)
      `ACC_MODE_BOTH: hit = rise | fall;
      `ACC_MODE_NEG: hit = fall;
      `ACC_MODE_POS: hit = rise;
      default: hit = 1'b0;
    endcase
  end
  wire cond = hit & active_run & status_live;

  // ****************************************
  // Interrupt enable next value
  // ****************************************
  // Shared by the enable register and the request output, so a write
  // that clears the enable drops the request in the same cycle
  reg ien_next;
  always @* begin
    ien_next = ien_reg;
    if (WR && sel(ADDR, `ACC_OFS_IEN)) begin
      ien_next = WDATA[0];
    end
  end

  // ****************************************
  // Interrupt flag
  // ****************************************
  // Flag next value: set wins over a clearing write
  always @* begin
    flag_next = flag_reg;
    if (WR && sel(ADDR, `ACC_OFS_STAT) && WDATA[`ACC_STAT_FLAG]) begin
      flag_next = 1'b0;
    end
    if (cond) begin
      flag_next = 1'b1;
    end
  end

  // ****************************************
  // Register storage
  // ****************************************
  // Control register
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_reg <= `ACC_RST_REG;
    end else if (WR && sel(ADDR, `ACC_OFS_CTRL)) begin
      ctrl_reg <= WDATA;
    end
  end

  // Input select register; reserved bits stay zero
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mux_reg <= `ACC_RST_REG;
    end else if (WR && sel(ADDR, `ACC_OFS_MUX)) begin
      mux_reg <= {WDATA[7], 5'h00, WDATA[1:0]};
    end
  end

  // Interrupt enable register
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ien_reg <= 1'b0;
    end else begin
      ien_reg <= ien_next;
    end
  end

  // Interrupt flag register
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // Edge history, frozen while status is not clocked, one flag per edge
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prev_reg <= 1'b0;
    end else if (status_live) begin
      prev_reg <= res;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  reg [7:0] rd_mux;
  reg state_reg;
  // Unmapped offsets read zero
  always @* begin
    rd_mux = 8'h00;
    case (ADDR)
      `ACC_OFS_CTRL: begin
        rd_mux = ctrl_reg;
      end
      `ACC_OFS_MUX: begin
        rd_mux = mux_reg;
      end
      `ACC_OFS_IEN: begin
        rd_mux = {7'h00, ien_reg};
      end
      `ACC_OFS_STAT: begin
        rd_mux[`ACC_STAT_STATE] = state_reg;
        rd_mux[`ACC_STAT_FLAG] = flag_reg;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  // Read data stands one cycle after the read strobe, else zero
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      RDATA <= rd_mux;
    end else begin
      RDATA <= 8'h00;
    end
  end

  // Status state is not updated when the clock would be stopped
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= 1'b0;
    end else if (status_live) begin
      state_reg <= res;
    end
  end

  // ****************************************
  // Core controls
  // ****************************************
  // Core enable
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CORE_EN <= 1'b0;
    end else begin
      CORE_EN <= active_run;
    end
  end

  // Low-power select
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CORE_LP <= 1'b0;
    end else begin
      CORE_LP <= lp_bit;
    end
  end

  // Hysteresis level
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CORE_HYS <= 2'b00;
    end else begin
      CORE_HYS <= hys;
    end
  end

  // Negative input select
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CORE_NEG_SEL <= `ACC_NEG_PIN;
    end else begin
      CORE_NEG_SEL <= mux_reg[1:0];
    end
  end

  // Positive input is the single pin
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CORE_POS_SEL <= 1'b0;
    end else begin
      CORE_POS_SEL <= 1'b0;
    end
  end

  // ****************************************
  // Event, pad and request outputs
  // ****************************************
  // Event output follows the result
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      EVENT_OUT <= 1'b0;
    end else begin
      EVENT_OUT <= res;
    end
  end

  // Pad value
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PAD_OUT <= 1'b0;
    end else begin
      PAD_OUT <= res & pin_output_enable_bit;
    end
  end

  // Pad drive enable
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PAD_OE <= 1'b0;
    end else begin
      PAD_OE <= active_run & pin_output_enable_bit;
    end
  end

  // Interrupt request from next enable and next flag
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= ien_next & flag_next;
    end
  end

  // Fixed vector
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      IRQ_VECTOR <= `ACC_IRQ_VECTOR;
    end else begin
      IRQ_VECTOR <= `ACC_IRQ_VECTOR;
    end
  end
endmodule // acc_ctrl
`default_nettype wire

// ===== rtl/acc_map.vh
`ifndef ACC_MAP_VH
`define ACC_MAP_VH
// ****************************************
// Register offsets
// ****************************************
`define ACC_OFS_CTRL 3'h0
`define ACC_OFS_MUX 3'h2
`define ACC_OFS_IEN 3'h6
`define ACC_OFS_STAT 3'h7
// ****************************************
// Field positions
// ****************************************
`define ACC_CTRL_EN 0
`define ACC_CTRL_HYS_LO 1
`define ACC_CTRL_LP 3
`define ACC_CTRL_MODE_LO 4
`define ACC_CTRL_PIN_OUTPUT_ENABLE 6
`define ACC_CTRL_RSTBY 7
`define ACC_MUX_INV 7
`define ACC_STAT_STATE 4
`define ACC_STAT_FLAG 0
// ****************************************
// Encodings and reset values
// ****************************************
`define ACC_MODE_BOTH 2'h0
`define ACC_MODE_NEG 2'h2
`define ACC_MODE_POS 2'h3
`define ACC_NEG_PIN 2'h0
`define ACC_NEG_VREF 2'h2
`define ACC_NEG_DAC 2'h3
`define ACC_RST_REG 8'h00
`define ACC_IRQ_VECTOR 8'h00
// ****************************************
// Timing
// ****************************************
`define ACC_CLK_MHZ 100
`define ACC_SYNC_STAGES 3
`define ACC_START_NS 2500
`define ACC_VREF_START_NS 60000
`endif

// ===== rtl/acc_sync.v
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Multi-stage level synchroniser
// ****************************************
module acc_sync #(
  parameter STAGES = 3
) (
  input wire clk,
  input wire arst_n,
  input wire d,
  output wire q
);
  reg [STAGES-1:0] chain_reg;
  // Shift chain; only the last stage is read
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chain_reg <= {STAGES{1'b0}};
    end else begin
      chain_reg <= {chain_reg[STAGES-2:0], d};
    end
  end
  assign q = chain_reg[STAGES-1];
endmodule // acc_sync
`default_nettype wire

// ===== tb/acc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module acc_core_model (
  input wire logic en,
  input var int vpos,
  input var int vneg,
  output logic res
);
  // Result is high only while running and the positive level is above the negative one
  assign res = en && (vpos > vneg);
endmodule // acc_core_model
`default_nettype wire

// ===== tb/acc_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module acc_ctrl_sva (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic SLEEP_PDOWN,
  input wire logic CORE_EN,
  input wire logic CORE_POS_SEL,
  input wire logic EVENT_OUT,
  input wire logic PAD_OUT,
  input wire logic PAD_OE,
  input wire logic IRQ,
  input wire logic [7:0] IRQ_VECTOR
);
  // One clock domain for every property
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  a_rdata_quiet: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data without read");
  a_pos_fixed: assert property (CORE_POS_SEL == 1'b0)
    else $error("positive select moved");
  a_vector_zero: assert property (IRQ_VECTOR == 8'h00)
    else $error("vector not zero");
  a_pdown_off: assert property ($past(SLEEP_PDOWN) |-> !CORE_EN && !PAD_OE)
    else $error("core on in power-down");
  a_irq_hold: assert property (IRQ && !WR |=> IRQ)
    else $error("request dropped");
  a_irq_drop: assert property (WR && ADDR == 3'h6 && !WDATA[0] |=> !IRQ)
    else $error("request without enable");
  a_pad_gate: assert property (!PAD_OE |-> !PAD_OUT)
    else $error("pad driven while off");
  a_event_gate: assert property (!CORE_EN && !$past(CORE_EN) |-> !EVENT_OUT)
    else $error("event while off");
  // Main scenarios
  c_irq: cover property ($rose(IRQ));
  c_pad: cover property ($rose(PAD_OE));
  c_event: cover property ($rose(EVENT_OUT));
endmodule // acc_ctrl_sva
bind acc_ctrl acc_ctrl_sva u_sva (.*);
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic CLK = 0, ARST_N = 0, WR = 0, RD = 0;
  logic [2:0] ADDR = 3'h0;
  logic [7:0] WDATA = 8'h00;
  logic [4:0] slp = 5'h00;
  wire CORE_OUT, CORE_EN, CORE_LP, CORE_POS_SEL, EVENT_OUT, PAD_OUT, PAD_OE, IRQ;
  wire [1:0] CORE_HYS, CORE_NEG_SEL;
  wire [7:0] RDATA, IRQ_VECTOR;
  int vp = 0;
  int failures = 0;
  int n_tests = 0;
  acc_ctrl dut (.CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .CORE_OUT(CORE_OUT), .SLEEP_IDLE(slp[4]), .SLEEP_STANDBY(slp[3]),
    .CLK_REQ_OTHER(slp[2]), .SLEEP_PDOWN(slp[1]), .DEBUG_HALT(slp[0]), .CORE_EN(CORE_EN),
    .CORE_LP(CORE_LP), .CORE_HYS(CORE_HYS), .CORE_NEG_SEL(CORE_NEG_SEL),
    .CORE_POS_SEL(CORE_POS_SEL), .EVENT_OUT(EVENT_OUT), .PAD_OUT(PAD_OUT), .PAD_OE(PAD_OE),
    .IRQ(IRQ), .IRQ_VECTOR(IRQ_VECTOR));
  acc_core_model core (.en(CORE_EN), .vpos(vp), .vneg(2), .res(CORE_OUT));
  // Clock
  always #5 CLK = ~CLK;
  // Compare and count
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task step(input int n);
    repeat (n) @(negedge CLK);
  endtask
  // Bus cycles
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    @(negedge CLK);
    chk("rdata", e, RDATA);
  endtask
  task sleep_set(input logic [4:0] v);
    @(posedge CLK);
    slp <= v;
  endtask
  task final_report;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #200000;
    failures++;
    final_report;
  end
  // Test sequence
  initial begin
    logic f;
    repeat (3) @(posedge CLK);
    ARST_N <= 1'b1;
    wr(3'h1, 8'hFF);
    for (int i = 0; i < 8; i++) rd(i[2:0], 8'h00);
    wr(3'h2, 8'hFF);
    rd(3'h2, 8'h83);
    chk("negsel", 8'h03, CORE_NEG_SEL);
    wr(3'h2, 8'h02);
    wr(3'h6, 8'h01);
    wr(3'h0, 8'h4F);
    step(6000);
    chk("negsel", 8'h02, CORE_NEG_SEL);
    chk("hys", 8'h03, CORE_HYS);
    chk("lp", 8'h01, CORE_LP);
    chk("en", 8'h01, CORE_EN);
    for (int m = 0; m < 4; m++) begin
      wr(3'h0, 8'h4F | 8'(m << 4));
      for (int e = 1; e >= 0; e--) begin
        vp <= e * 5;
        f = (m == 0) || (m == 2 && e == 0) || (m == 3 && e == 1);
        step(8);
        chk("event", e[0], EVENT_OUT);
        chk("pad", e[0], PAD_OUT);
        chk("irq", f, IRQ);
        rd(3'h7, {3'h0, e[0], 3'h0, f});
        wr(3'h7, 8'h01);
      end
    end
    wr(3'h2, 8'h80);
    step(8);
    chk("event", 8'h01, EVENT_OUT);
    rd(3'h7, 8'h11);
    wr(3'h6, 8'h00);
    step(1);
    chk("irq", 8'h00, IRQ);
    wr(3'h7, 8'h01);
    wr(3'h2, 8'h00);
    sleep_set(5'h11);
    step(3);
    chk("en", 8'h01, CORE_EN);
    sleep_set(5'h08);
    step(3);
    chk("en", 8'h00, CORE_EN);
    wr(3'h0, 8'hCF);
    step(250);
    chk("en", 8'h01, CORE_EN);
    vp <= 5;
    step(8);
    chk("event", 8'h01, EVENT_OUT);
    chk("pad", 8'h01, PAD_OUT);
    rd(3'h7, 8'h00);
    sleep_set(5'h0C);
    step(8);
    rd(3'h7, 8'h11);
    sleep_set(5'h02);
    step(3);
    chk("en", 8'h00, CORE_EN);
    chk("oe", 8'h00, PAD_OE);
    final_report;
  end
endmodule // tb
`default_nettype wire
